// >>> logic/cdac_pkg.sv
// Package of constants and types for the current DAC serial slave
// Contract
// (RQ1) When addressed, acknowledge every received byte by pulling data low.
// (RQ2) Master gives one extra clock pulse after each byte for acknowledge.
// (RQ3) Receiver holds data low and stable through the acknowledge clock high.
// (RQ4) A data byte is seven code bits followed by one flag bit.
// (RQ5) On reads the flag is 1 when storage is idle, 0 while programming.
// (RQ6) Write flag 1 updates register only; flag 0 also programs storage. Code skips programming while storage is already busy.
// (RQ7) Master must keep power on while a read reports programming busy.
// (RQ8) Every operation ends with data rising while clock is high.
// (RQ9) The link works correctly at bus rates up to 400 kbps.
// (RQ10) Output fraction is code plus one over 128 of full scale.
// (RQ11) After start, address plus direction bit; answer only to 9E hex.
// (RQ12) Direction high returns the register; direction low accepts a new code.
// (RQ13) Write-protect low or floating blocks storage programming, register still writable.
// (RQ14) At power-up the stored code is copied into the register.
// (RQ15) On address mismatch keep data released and ignore the transfer.
package cdac_pkg;
    localparam logic [7:0]  SLAVE_ADDR_BYTE = 8'h9E;
    localparam logic [6:0]  SLAVE_ADDR7     = SLAVE_ADDR_BYTE[7:1];
    localparam logic [3:0]  BYTE_BITS       = 4'h8;
    localparam logic [7:0]  LEVEL_OFFSET    = 8'h01;
    localparam int          CLK_MHZ         = 200;
    // Programming time is not specified; plain default
    localparam int          NV_PROG_TIME_US = 10;
    localparam int          NV_PROG_CYCLES  = NV_PROG_TIME_US * CLK_MHZ;
    localparam logic [15:0] NV_PROG_CNT     = 16'(NV_PROG_CYCLES);
    // Code held in storage after reset; arbitrary default
    localparam logic [6:0]  NV_INIT_CODE    = 7'h40;

    typedef enum logic [3:0] {
        ST_LOAD, ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA,
        ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
    } cdac_st_t;

    typedef struct packed {
        logic       scl_m, scl_s, scl_p;
        logic       sda_m, sda_s, sda_p;
        logic       wp_m,  wp_s;
        cdac_st_t   st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       rw;
        logic [6:0] code;
        logic [7:0] level;
        logic       sda_oe;
        logic       sda_o;
        logic       wp_p;
        logic       prog_req;
        logic [6:0] prog_code;
    } cdac_main_t;

    typedef struct packed {
        logic        busy;
        logic [15:0] cnt;
        logic [6:0]  pend;
        logic [6:0]  stored;
    } cdac_nvm_st_t;
endpackage

// >>> logic/cdac_nvm_if.sv
// Interface between the serial slave and the non-volatile store
`timescale 1ns/1ps
`default_nettype none
interface cdac_nvm_if;
    logic       prog_req;
    logic [6:0] prog_code;
    logic       busy;
    logic [6:0] stored;
    modport ctrl  (output prog_req, output prog_code, input busy, input stored);
    modport store (input prog_req, input prog_code, output busy, output stored);
endinterface
`default_nettype wire

// >>> logic/cdac_nvm.sv
// Non-volatile code store with a timed programming cycle
`timescale 1ns/1ps
`default_nettype none
module cdac_nvm
    import cdac_pkg::*;
#(
    parameter logic [15:0] PROG_CNT = NV_PROG_CNT
) (
    input  wire logic     i_ref_clk,
    input  wire logic     i_resetn,
    cdac_nvm_if.store     nvm
);
    cdac_nvm_st_t q, d;

    always_comb begin
        d = q;
        if (q.busy) begin
            if (q.cnt == 16'h0000) begin
                // New code only becomes visible once the cycle is done
                d.busy   = 1'b0;
                d.stored = q.pend;
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
        end else if (nvm.prog_req) begin
            d.busy = 1'b1;
            d.cnt  = PROG_CNT - 16'h0001;
            d.pend = nvm.prog_code;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '{busy: 1'b0, cnt: 16'h0000, pend: NV_INIT_CODE, stored: NV_INIT_CODE};
        end else begin
            q <= d;
        end
    end

    assign nvm.busy   = q.busy;
    assign nvm.stored = q.stored;

    // (RQ7) Busy window length
    a_prog_busy_hold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn) // RQ7
        $rose(q.busy) |-> q.busy [*8]) else $error("programming ended too early");
endmodule
`default_nettype wire

// >>> logic/cdac_serial_slave.sv
// Two-wire serial slave setting a 7-bit current DAC code
`timescale 1ns/1ps
`default_nettype none
module cdac_serial_slave
    import cdac_pkg::*;
#(
    parameter logic [15:0] PROG_CNT = NV_PROG_CNT
) (
    input  wire logic       i_ref_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_wp_n,
    output logic            o_sda,
    output logic            o_sda_oe,
    output logic            o_wp_p,
    output logic [6:0]      o_dac_code,
    output logic [7:0]      o_dac_level,
    output logic            o_nv_busy
);
    cdac_main_t q, d;
    cdac_nvm_if nvm ();

    cdac_nvm #(
        .PROG_CNT (PROG_CNT)
    ) u_nvm (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .nvm       (nvm)
    );

    logic scl_rise, scl_fall, start_c, stop_c, wr_done;
    assign scl_rise = q.scl_s & ~q.scl_p;
    assign scl_fall = ~q.scl_s & q.scl_p;
    assign start_c  = q.scl_s & q.scl_p & ~q.sda_s & q.sda_p;
    assign stop_c   = q.scl_s & q.scl_p & q.sda_s & ~q.sda_p;
    assign wr_done  = (q.st == ST_WDATA) && scl_fall && (q.cnt == BYTE_BITS);

    always_comb begin
        d = q;
        // (RQ9) Oversampled two-stage sync
        d.scl_m    = i_scl;
        d.scl_s    = q.scl_m;
        d.scl_p    = q.scl_s;
        d.sda_m    = i_sda;
        d.sda_s    = q.sda_m;
        d.sda_p    = q.sda_s;
        d.wp_m     = i_wp_n;
        d.wp_s     = q.wp_m;
        d.wp_p     = ~q.wp_s;
        d.prog_req = 1'b0;
        case (q.st)
            ST_LOAD: begin
                // (RQ14) Power-up copy
                d.code = nvm.stored;
                d.st   = ST_IDLE;
            end
            ST_IDLE, ST_IGNORE: begin
                d.sda_oe = 1'b0;
            end
            ST_ADDR, ST_WDATA: begin
                // (RQ4) Eight bit shift
                if (scl_rise) begin
                    d.sh  = {q.sh[6:0], q.sda_s};
                    d.cnt = q.cnt + 4'h1;
                end
                if (scl_fall && q.cnt == BYTE_BITS) begin
                    if (q.st == ST_ADDR) begin
                        // (RQ11) Address match
                        if (q.sh[7:1] == SLAVE_ADDR7) begin
                            d.rw     = q.sh[0];
                            d.sda_oe = 1'b1;
                            d.st     = ST_ADDR_ACK;
                        end else begin
                            // (RQ15) Stay off the bus
                            d.st = ST_IGNORE;
                        end
                    end else begin
                        // (RQ6) Flag picks destination
                        d.code = q.sh[7:1];
                        // A flag 0 byte while busy lands in the register only
                        // (RQ13) Write-protect gate
                        if (!q.sh[0] && q.wp_s && !nvm.busy) begin
                            d.prog_req  = 1'b1;
                            d.prog_code = q.sh[7:1];
                        end
                        // (RQ1) Ack data byte
                        d.sda_oe = 1'b1;
                        d.st     = ST_WACK;
                    end
                end
            end
            ST_ADDR_ACK, ST_WACK, ST_RACK: begin
                // Master ack or nack is sampled on the rising edge
                if (q.st == ST_RACK && scl_rise && q.sda_s) begin
                    d.st = ST_IGNORE;
                end
                // (RQ3) Held until clock falls
                if (scl_fall) begin
                    d.cnt = 4'h0;
                    // (RQ12) Direction select
                    if (q.rw && q.st != ST_WACK) begin
                        // (RQ5) Flag is ready-not-busy
                        d.sh     = {q.code, ~nvm.busy};
                        d.sda_oe = ~q.code[6];
                        d.st     = ST_RDATA;
                    end else begin
                        d.sda_oe = 1'b0;
                        d.st     = ST_WDATA;
                    end
                end
            end
            ST_RDATA: begin
                if (scl_rise) begin
                    d.cnt = q.cnt + 4'h1;
                end
                if (scl_fall) begin
                    if (q.cnt == BYTE_BITS) begin
                        d.sda_oe = 1'b0;
                        d.st     = ST_RACK;
                    end else begin
                        d.sh     = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase
        if (q.st != ST_LOAD) begin
            if (start_c) begin
                d.st     = ST_ADDR;
                d.cnt    = 4'h0;
                d.sda_oe = 1'b0;
            end
            // (RQ8) Stop ends the operation
            if (stop_c) begin
                d.st     = ST_IDLE;
                d.sda_oe = 1'b0;
            end
        end
        // (RQ10) Level is code plus one
        d.level = {1'b0, d.code} + LEVEL_OFFSET;
    end

    // SCL and SDA sync flops reset to the idle bus level so no false edge follows reset
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            q <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.wp_p  <= 1'b1;
            q.level <= LEVEL_OFFSET;
            q.st    <= ST_LOAD;
        end else begin
            q <= d;
        end
    end

    assign nvm.prog_req  = q.prog_req;
    assign nvm.prog_code = q.prog_code;
    assign o_sda         = q.sda_o;
    assign o_sda_oe      = q.sda_oe;
    assign o_wp_p        = q.wp_p;
    assign o_dac_code    = q.code;
    assign o_dac_level   = q.level;
    assign o_nv_busy     = nvm.busy;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    a_ack_addr_byte: assert property (((q.st == ST_ADDR) && scl_fall // RQ1
        && (q.cnt == BYTE_BITS) && (q.sh[7:1] == SLAVE_ADDR7))
        |=> o_sda_oe && (q.st == ST_ADDR_ACK))
        else $error("address not acknowledged");
    a_addr_miss_off: assert property (((q.st == ST_ADDR) && scl_fall // RQ15
        && (q.cnt == BYTE_BITS) && (q.sh[7:1] != SLAVE_ADDR7))
        |=> (q.st == ST_IGNORE) && !o_sda_oe)
        else $error("foreign address not ignored");
    a_ack_data_byte: assert property (wr_done |=> o_sda_oe && (q.st == ST_WACK)) // RQ1
        else $error("data byte not acknowledged");
    a_ack_held_high: assert property (((q.st == ST_ADDR_ACK) || (q.st == ST_WACK)) // RQ3
        && q.scl_s |-> o_sda_oe)
        else $error("ack released while clock high");
    // Read bit may only move while the synced clock is low
    a_read_bit_hold: assert property ((q.st == ST_RDATA) && q.scl_s |-> $stable(o_sda_oe)) // RQ3
        else $error("read bit moved while clock high");
    a_mismatch_quiet: assert property ((q.st == ST_IGNORE) |-> !o_sda_oe) // RQ15
        else $error("driving bus when not addressed");
    a_read_flag_val: assert property (((q.st == ST_ADDR_ACK) || (q.st == ST_RACK)) // RQ5
        && q.rw && scl_fall |=> (q.st == ST_RDATA) && (q.sh[0] == !$past(nvm.busy)))
        else $error("read flag does not reflect busy");
    a_reg_only_write: assert property (wr_done && q.sh[0] |=> !nvm.prog_req // RQ6
        && (o_dac_code == $past(q.sh[7:1])))
        else $error("register write misrouted");
    a_nv_write_go: assert property (wr_done && !q.sh[0] && q.wp_s && !nvm.busy // RQ6
        |=> nvm.prog_req && (nvm.prog_code == o_dac_code))
        else $error("storage write not issued");
    a_wp_blocks_nv: assert property (!q.wp_s |=> !nvm.prog_req) // RQ13
        else $error("programming while protected");
    a_stop_to_idle: assert property (stop_c && (q.st != ST_LOAD) // RQ8
        |=> (q.st == ST_IDLE) && !o_sda_oe)
        else $error("stop did not end transfer");
    a_level_tracks: assert property (o_dac_level == ({1'b0, o_dac_code} + LEVEL_OFFSET)) // RQ10
        else $error("level not code plus one");
    // Sampled reset must be high already, or the release edge itself would fire this
    a_power_up_load: assert property ((q.st == ST_LOAD) && i_resetn // RQ14
        |=> (o_dac_code == $past(nvm.stored)) && (q.st != ST_LOAD))
        else $error("stored code not loaded");
    a_read_dir_only: assert property ((q.st == ST_ADDR_ACK) && !q.rw && scl_fall // RQ12
        |=> (q.st == ST_WDATA) && !o_sda_oe)
        else $error("write direction mishandled");

    c_reg_write:  cover property (wr_done && q.sh[0]);
    c_nv_write:   cover property (nvm.prog_req);
    c_read_busy:  cover property ((q.st == ST_RDATA) && nvm.busy);
    c_addr_miss:  cover property ((q.st == ST_IGNORE));
    c_read_more:  cover property ((q.st == ST_RACK) && scl_rise && !q.sda_s);
endmodule
`default_nettype wire

// >>> verification/cdac_bus_master.sv
// Bus master model driving the two-wire link of the DAC slave
`timescale 1ns/1ps
`default_nettype none
module cdac_bus_master (
    input  wire logic i_ref_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // link rate
    // Quarter of the 80 ns link period, counted in 5 ns cycles
    localparam int Q = 4;
    logic unstable = 1'b0;
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic step(input logic c, input logic d);
        repeat (Q) @(posedge i_ref_clk);
        o_scl    <= c;
        o_sda_oe <= d;
    endtask
    task automatic start();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
    endtask
    task automatic bit_x(input logic b, output logic r);
        step(1'b0, ~b);
        step(1'b1, ~b);
        step(1'b1, ~b);
        r = i_sda;
        step(1'b0, ~b);
        if (i_sda !== r) unstable = 1'b1;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic ack);
        logic t;
        for (int i = 7; i >= 0; i--) begin
            bit_x(tx[i], t);
            rx[i] = t;
        end
        bit_x(ak, ack);
    endtask
endmodule
`default_nettype wire

// >>> verification/test_current_dac_serial_slave.sv
// Self-checking bench for the current DAC serial slave
`timescale 1ns/1ps
`default_nettype none
module test_current_dac_serial_slave;
    import cdac_pkg::*;
    // Long enough that a read right after a program still sees busy
    localparam logic [15:0] PROG = 16'h0190;
    typedef struct packed {
        logic [6:0] code;
        logic       flag;
        logic       wp_n;
        logic       prog;
    } cdac_row_t;
    cdac_row_t  rows [5] = '{'{7'h00, 1, 1, 0}, '{7'h7F, 1, 1, 0}, '{7'h15, 0, 0, 0},
                             '{7'h2A, 0, 1, 1}, '{7'h55, 1, 0, 0}};
    logic       ref_clk   = 1'b0;
    logic       resetn    = 1'b0;
    logic       wp_n      = 1'b0;
    logic       oe_seen   = 1'b0;
    logic       busy_seen = 1'b0;
    logic       scl, m_oe, d_sda, d_oe, wp_p, busy;
    logic [6:0] code;
    logic [7:0] level;
    wire        sda_w;
    int         err_count  = 0;
    int         n_compared = 0;
    assign sda_w = ~(m_oe | d_oe);
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (d_oe === 1'b1) oe_seen <= 1'b1;
        if (busy === 1'b1) busy_seen <= 1'b1;
    end
    cdac_serial_slave #(.PROG_CNT(PROG)) DUT (
        .i_ref_clk  (ref_clk),
        .i_resetn   (resetn),
        .i_scl      (scl),
        .i_sda      (sda_w),
        .i_wp_n     (wp_n),
        .o_sda      (d_sda),
        .o_sda_oe   (d_oe),
        .o_wp_p     (wp_p),
        .o_dac_code (code),
        .o_dac_level(level),
        .o_nv_busy  (busy)
    );
    cdac_bus_master bm (
        .i_ref_clk(ref_clk),
        .i_sda    (sda_w),
        .o_scl    (scl),
        .o_sda_oe (m_oe)
    );
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask
    task automatic finish_test();
        $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic txn(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rx,
                       output logic aa, output logic ad);
        bm.start();
        bm.xfer(a, 1'b1, rx, aa);
        bm.xfer(d, 1'b1, rx, ad);
        bm.stop();
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge ref_clk);
        check("busy_end", busy, 8'h00);
    endtask
    initial begin
        cdac_row_t  r;
        logic [7:0] rx;
        logic [7:0] rx2;
        logic       aa;
        logic       ad;
        repeat (5) @(posedge ref_clk);
        check("oe_reset", d_oe, 8'h00);
        check("sda_reset", d_sda, 8'h00);
        check("level_reset", level, 8'h01);
        resetn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("boot_code", code, NV_INIT_CODE);
        check("boot_level", level, {1'b0, NV_INIT_CODE} + LEVEL_OFFSET);
        $display("Test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            wp_n <= r.wp_n;
            busy_seen = 1'b0;
            txn(SLAVE_ADDR_BYTE, {r.code, r.flag}, rx, aa, ad);
            check("addr_ack", aa, 8'h00);
            check("data_ack", ad, 8'h00);
            check("code", code, r.code);
            check("level", level, {1'b0, r.code} + 8'h01);
            check("prog", busy_seen, r.prog);
            check("wp_p", wp_p, {7'h00, ~r.wp_n});
            wait_idle();
            txn(SLAVE_ADDR_BYTE | 8'h01, 8'hFF, rx, aa, ad);
            check("read", rx, {r.code, 1'b1});
            $display("Test row %0d done", i);
        end
        wp_n <= 1'b1;
        txn(SLAVE_ADDR_BYTE, {7'h33, 1'b0}, rx, aa, ad);
        txn(SLAVE_ADDR_BYTE | 8'h01, 8'hFF, rx, aa, ad);
        check("read_busy", rx, {7'h33, 1'b0});
        wait_idle();
        $display("Test busy read done");
        bm.start();
        bm.xfer(SLAVE_ADDR_BYTE | 8'h01, 1'b1, rx, aa);
        bm.xfer(8'hFF, 1'b0, rx, ad);
        bm.xfer(8'hFF, 1'b1, rx2, ad);
        bm.stop();
        check("read_b1", rx, {7'h33, 1'b1});
        check("read_b2", rx2, {7'h33, 1'b1});
        $display("Test two byte read done");
        oe_seen = 1'b0;
        txn(8'h90, {7'h11, 1'b1}, rx, aa, ad);
        check("other_addr", aa, 8'h01);
        check("other_data", ad, 8'h01);
        check("other_oe", oe_seen, 8'h00);
        check("other_code", code, 8'h33);
        $display("Test foreign address done");
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check("mid_reset_code", code, 8'h00);
        check("mid_reset_oe", d_oe, 8'h00);
        resetn <= 1'b1;
        repeat (5) @(posedge ref_clk);
        check("mid_boot_code", code, NV_INIT_CODE);
        check("mid_boot_level", level, {1'b0, NV_INIT_CODE} + LEVEL_OFFSET);
        check("sda_out", d_sda, 8'h00);
        $display("Test mid reset done");
        check("ack_stable", bm.unstable, 8'h00);
        finish_test();
    end
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
